// [lane_layer.sv]
// Behaviour
// - an accepted send request puts its word out on the serial lane
// - ready to accept is signalled in the active state whenever the outgoing word slot is free
// - each word received in the active state goes upward with a one-cycle receive strobe
// - a lane status strobe accompanies every change of the lane status
// - receive error counter starts at eight and counts up on each error
// - receive error counter counts down once every thirty-two received words
// - counter at zero means clock-data recovery is locked
// - power-on reset or full-reset command enters the full reset state
// - full reset clears lane and config, sets hard flag, powers line down
// - full reset state moves straight to the line quiet state unless a new full-reset command is pending
// - line quiet entered after full reset and from anywhere on soft reset
// - 20 us start timeout sends start-up states back to line quiet
// - eight consecutive loss or standby words force line quiet
// - no signal in flip, connecting or connected states forces line quiet
// - sleep and signal-gone states leave after sending 32 of their words
// - line quiet starts a 2 us timer, powers line down, keeps config
// - line quiet turns off receive bit inversion
// - line quiet exits: full reset first, then timer expiry to disabled
// - disabled goes to wait on lane start or self go without reset
`timescale 1ns/1ns
module lane_layer (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // upper layer side
    input  wire logic        tx_req,
    input  wire logic [31:0] tx_word,
    output logic             tx_ready,
    output logic             up_valid,
    output logic [31:0]      up_word,
    output logic             status_ind,
    output logic             status_ready,
    // line side
    output logic             line_valid,
    output logic [31:0]      line_word,
    input  wire logic        line_accept,
    input  wire logic        rx_valid,
    input  wire logic [31:0] rx_word,
    input  wire logic        rx_ctrl,
    input  wire logic        rx_err,
    input  wire logic        no_signal,
    input  wire logic        init_match,
    input  wire logic        init_inverse,
    output logic             rx_invert,
    output logic             tx_drv_en,
    output logic             tx_pll_en,
    output logic             rx_en,
    output logic             rx_cdr_en
);
    typedef struct packed {
        lane_pkg::lane_state_e state;
        logic                  hard_flag;
        logic                  lane_start;
        logic                  self_go;
        logic                  full_req;
        logic                  soft_req;
        logic                  sleep_req;
        logic                  loss_req;
        logic                  rx_invert;
        logic [3:0]            los_cnt;
        logic [3:0]            sby_cnt;
        logic [5:0]            sent_cnt;
        logic                  line_valid;
        logic [31:0]           line_word;
        logic                  tx_ready;
        logic                  up_valid;
        logic [31:0]           up_word;
        logic                  status_ind;
        logic                  status_ready;
        logic [3:0]            pwr;
        logic                  dph_wr;
        logic [7:0]            dph_addr;
        logic [31:0]           hrdata;
    } lane_s;

    lane_s       st_reg;
    lane_s       st_next;
    logic        init_expired;
    logic        quiet_expired;
    logic        err_locked;
    logic [7:0]  err_count;
    logic        enter;
    logic        los_word;
    logic        sby_word;
    logic        addr_ph;
    logic        startup;
    logic        slot_free;
    logic [31:0] status_val;
    logic [31:0] ctrl_val;

    // 20 us start-up timeout: runs from started until active
    lane_timer #(
        .CYCLES (lane_pkg::init_timeout_cyc)
    ) u_init_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (enter && st_next.state == lane_pkg::started_state),
        .stop    (st_reg.state == lane_pkg::active_state
                  || st_reg.state == lane_pkg::line_quiet_state),
        .expired (init_expired)
    );

    // 2 us line quiet timer
    lane_timer #(
        .CYCLES (lane_pkg::quiet_time_cyc)
    ) u_quiet_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .start   (enter && st_next.state == lane_pkg::line_quiet_state),
        .stop    (st_reg.state != lane_pkg::line_quiet_state && !enter),
        .expired (quiet_expired)
    );

    // receive lock detection, reloaded on entry to started
    rx_err_counter u_rx_err (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .load     (enter && st_next.state == lane_pkg::started_state),
        .rx_valid (rx_valid),
        .rx_err   (rx_err),
        .count    (err_count),
        .locked   (err_locked)
    );

    // register read values
    always_comb begin
        status_val = '0;
        status_val[lane_pkg::stat_state_hi:lane_pkg::stat_state_lo] = st_reg.state;
        status_val[lane_pkg::stat_hard_flag]  = st_reg.hard_flag;
        status_val[lane_pkg::stat_locked]     = err_locked;
        status_val[lane_pkg::stat_lane_ready] = st_reg.status_ready;
        status_val[lane_pkg::stat_rx_invert]  = st_reg.rx_invert;
        ctrl_val = '0;
        ctrl_val[lane_pkg::ctrl_lane_start]   = st_reg.lane_start;
        ctrl_val[lane_pkg::ctrl_self_go]      = st_reg.self_go;
    end

    assign addr_ph   = hsel && hready && (htrans == lane_pkg::htrans_nonseq
                                          || htrans == lane_pkg::htrans_seq);
    assign los_word  = rx_valid && rx_ctrl && rx_word == lane_pkg::lost_signal_word;
    assign sby_word  = rx_valid && rx_ctrl && rx_word == lane_pkg::standby_word;
    assign startup   = st_reg.state == lane_pkg::started_state
                       || st_reg.state == lane_pkg::polarity_flip_state
                       || st_reg.state == lane_pkg::connecting_state
                       || st_reg.state == lane_pkg::connected_state;
    assign slot_free = !st_reg.line_valid || line_accept;
    assign enter     = st_next.state != st_reg.state
                       || (st_reg.state == lane_pkg::line_quiet_state && st_reg.soft_req);

    // bus slave, lane state machine and data paths
    always_comb begin
        st_next            = st_reg;
        st_next.status_ind = 1'b0;
        st_next.up_valid   = 1'b0;

        // address phase: latch write target, prepare read data
        st_next.dph_wr   = addr_ph && hwrite;
        st_next.dph_addr = haddr;
        if (addr_ph && !hwrite) begin
            unique case (haddr)
                lane_pkg::ctrl_addr:   st_next.hrdata = ctrl_val;
                lane_pkg::status_addr: st_next.hrdata = status_val;
                lane_pkg::rxerr_addr:  st_next.hrdata = {24'h000000, err_count};
                default:               st_next.hrdata = '0;
            endcase
        end

        // data phase writes; command bits are requests held until acted on
        if (st_reg.dph_wr && st_reg.dph_addr == lane_pkg::ctrl_addr) begin
            st_next.lane_start = hwdata[lane_pkg::ctrl_lane_start];
            st_next.self_go    = hwdata[lane_pkg::ctrl_self_go];
            st_next.full_req   = st_reg.full_req | hwdata[lane_pkg::ctrl_full_reset];
            st_next.soft_req   = st_reg.soft_req | hwdata[lane_pkg::ctrl_soft_reset];
            st_next.sleep_req  = st_reg.sleep_req | hwdata[lane_pkg::ctrl_sleep_req];
            st_next.loss_req   = st_reg.loss_req | hwdata[lane_pkg::ctrl_loss_req];
        end
        if (st_reg.dph_wr && st_reg.dph_addr == lane_pkg::status_addr
            && hwdata[lane_pkg::stat_hard_flag]) begin
            st_next.hard_flag = 1'b0;
        end

        // consecutive loss / standby word counters
        if (rx_valid) begin
            st_next.los_cnt = los_word ? st_reg.los_cnt + 4'h1 : 4'h0;
            st_next.sby_cnt = sby_word ? st_reg.sby_cnt + 4'h1 : 4'h0;
        end

        // transmit slot drains when the line takes the word
        if (line_accept) begin
            st_next.line_valid = 1'b0;
        end

        // state transitions
        unique case (st_reg.state)
            lane_pkg::full_reset_state: begin
                st_next.state = lane_pkg::line_quiet_state;
            end
            lane_pkg::line_quiet_state: begin
                if (quiet_expired) begin
                    st_next.state = lane_pkg::disabled_state;
                end
            end
            lane_pkg::disabled_state: begin
                if (st_reg.lane_start || st_reg.self_go) begin
                    st_next.state = lane_pkg::wait_state;
                end
            end
            lane_pkg::wait_state: begin
                if (!st_reg.lane_start && !st_reg.self_go) begin
                    st_next.state = lane_pkg::disabled_state;
                end else if (st_reg.lane_start || !no_signal) begin
                    st_next.state = lane_pkg::started_state;
                end
            end
            lane_pkg::started_state: begin
                if (init_match) begin
                    st_next.state = lane_pkg::connecting_state;
                end else if (init_inverse) begin
                    st_next.state = lane_pkg::polarity_flip_state;
                end
            end
            lane_pkg::polarity_flip_state: begin
                st_next.rx_invert = 1'b1;
                st_next.state     = lane_pkg::started_state;
            end
            lane_pkg::connecting_state: begin
                if (err_locked) begin
                    st_next.state = lane_pkg::connected_state;
                end
            end
            lane_pkg::connected_state: begin
                if (init_match) begin
                    st_next.state = lane_pkg::active_state;
                end
            end
            lane_pkg::active_state: begin
                if (st_reg.sleep_req) begin
                    st_next.state     = lane_pkg::sleep_prepare_state;
                    st_next.sleep_req = 1'b0;
                    st_next.sent_cnt  = '0;
                end else if (st_reg.loss_req) begin
                    st_next.state    = lane_pkg::signal_gone_state;
                    st_next.loss_req = 1'b0;
                    st_next.sent_cnt = '0;
                end
            end
            lane_pkg::sleep_prepare_state, lane_pkg::signal_gone_state: begin
                if (slot_free) begin
                    st_next.line_valid = 1'b1;
                    st_next.line_word  = (st_reg.state == lane_pkg::sleep_prepare_state)
                                         ? lane_pkg::standby_word
                                         : lane_pkg::lost_signal_word;
                    st_next.sent_cnt   = st_reg.sent_cnt + 6'h01;
                    if (st_reg.sent_cnt == lane_pkg::sleep_words_last) begin
                        st_next.state = lane_pkg::line_quiet_state;
                    end
                end
            end
        endcase

        // overriding exits, lowest priority first
        if (startup && init_expired) begin
            st_next.state = lane_pkg::line_quiet_state;
        end
        if ((st_reg.state == lane_pkg::polarity_flip_state
             || st_reg.state == lane_pkg::connecting_state
             || st_reg.state == lane_pkg::connected_state) && no_signal) begin
            st_next.state = lane_pkg::line_quiet_state;
        end
        if (st_reg.state != lane_pkg::full_reset_state
            && ((los_word && st_reg.los_cnt == lane_pkg::consec_last)
                || (sby_word && st_reg.sby_cnt == lane_pkg::consec_last))) begin
            st_next.state = lane_pkg::line_quiet_state;
        end
        if (st_reg.soft_req) begin
            st_next.soft_req = 1'b0;
            st_next.state    = lane_pkg::line_quiet_state;
        end
        if (st_reg.full_req) begin
            st_next.full_req = 1'b0;
            st_next.state    = lane_pkg::full_reset_state;
        end

        // per-state actions
        unique case (st_reg.state)
            lane_pkg::full_reset_state: begin
                st_next.hard_flag  = 1'b1;
                st_next.lane_start = 1'b0;
                st_next.self_go    = 1'b0;
                st_next.rx_invert  = 1'b0;
                st_next.sleep_req  = 1'b0;
                st_next.loss_req   = 1'b0;
                st_next.line_valid = 1'b0;
                st_next.los_cnt    = '0;
                st_next.sby_cnt    = '0;
                st_next.pwr        = 4'h0;
            end
            lane_pkg::line_quiet_state: begin
                st_next.rx_invert  = 1'b0;
                st_next.line_valid = 1'b0;
                st_next.pwr        = 4'h0;
            end
            lane_pkg::disabled_state: st_next.pwr = 4'h0;
            lane_pkg::wait_state:     st_next.pwr = 4'h3; // receiver and recovery only
            default:                  st_next.pwr = 4'hf;
        endcase

        // upper layer transmit path: accept into the free slot
        if (st_reg.state == lane_pkg::active_state && tx_req && st_reg.tx_ready) begin
            st_next.line_valid = 1'b1;
            st_next.line_word  = tx_word;
        end
        st_next.tx_ready = st_next.state == lane_pkg::active_state
                           && !st_next.line_valid;

        // receive path, only while the lane is in use
        if (rx_valid && st_reg.state == lane_pkg::active_state) begin
            st_next.up_valid = 1'b1;
            st_next.up_word  = rx_word;
        end

        // lane status bit and change strobe
        st_next.status_ready = st_next.state == lane_pkg::active_state;
        st_next.status_ind   = st_next.status_ready != st_reg.status_ready;
    end

    // power-on reset lands in the full reset state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg       <= '0;
            st_reg.state <= lane_pkg::full_reset_state;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state flops
    assign hreadyout    = 1'b1 | st_reg.dph_wr; // zero wait states
    assign hrdata       = st_reg.hrdata;
    assign hresp        = 1'b0 & st_reg.dph_wr;
    assign tx_ready     = st_reg.tx_ready;
    assign up_valid     = st_reg.up_valid;
    assign up_word      = st_reg.up_word;
    assign status_ind   = st_reg.status_ind;
    assign status_ready = st_reg.status_ready;
    assign line_valid   = st_reg.line_valid;
    assign line_word    = st_reg.line_word;
    assign rx_invert    = st_reg.rx_invert;
    assign tx_drv_en    = st_reg.pwr[3];
    assign tx_pll_en    = st_reg.pwr[2];
    assign rx_en        = st_reg.pwr[1];
    assign rx_cdr_en    = st_reg.pwr[0];
endmodule : lane_layer

// [lane_layer_chk_assertions.sv]
`timescale 1ns/1ns
// port-level timing checks of the lane layer
module lane_layer_chk (
    input wire logic        ref_clk, resetn, tx_req, tx_ready, line_valid, line_accept,
    input wire logic        rx_valid, up_valid, status_ind, status_ready,
    input wire logic        tx_drv_en, tx_pll_en, rx_en, rx_cdr_en,
    input wire logic [31:0] line_word
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_TAKE: assert property (tx_req && tx_ready |=> line_valid)
        else $error("taken word not put on the line");
    AST_HOLD: assert property (line_valid && !line_accept |=> line_valid && $stable(line_word))
        else $error("line word dropped before accept");
    AST_BUSY: assert property (line_valid && !line_accept |=> !tx_ready)
        else $error("ready while slot full");
    AST_IDLE: assert property (!status_ready |-> !tx_ready)
        else $error("ready while lane not ready");
    AST_UP: assert property (rx_valid && status_ready |=> up_valid)
        else $error("received word not passed up");
    AST_IND: assert property (status_ind == (status_ready != $past(status_ready)))
        else $error("status strobe out of step");
    AST_PWR: assert property (tx_drv_en |-> tx_pll_en && rx_en && rx_cdr_en)
        else $error("driver on without pll and receiver");
    AST_OFF: assert property ($rose(resetn) |-> (!rx_en && !tx_drv_en) [*8])
        else $error("line powered during reset states");
    cover property (status_ind && status_ready);
    cover property (line_valid && !line_accept);
    cover property (up_valid);
endmodule : lane_layer_chk

// [lane_layer_tb.sv]
`timescale 1ns/1ns
module lane_layer_tb;
    localparam logic [7:0] sa = lane_pkg::status_addr;
    localparam logic [7:0] ca = lane_pkg::ctrl_addr;
    logic ref_clk = 0, resetn = 0, hsel = 0, hwrite = 0, tx_req = 0, stall = 1;
    logic rx_valid = 0, rx_ctrl = 0, rx_err = 0, no_signal = 0, init_match = 0, init_inverse = 0;
    logic [7:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [31:0] hwdata = '0, tx_word = '0, rx_word = '0, hrdata, up_word, line_word, got, rd;
    logic hreadyout, hresp, tx_ready, up_valid, status_ind, status_ready, line_valid;
    logic line_accept, rx_invert, tx_drv_en, tx_pll_en, rx_en, rx_cdr_en;
    int failures = 0, checks_done = 0, n;
    // free-running system clock
    always #10 ref_clk = ~ref_clk;
    lane_layer lane_layer_i (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .tx_req, .tx_word, .tx_ready,
        .up_valid, .up_word, .status_ind, .status_ready, .line_valid, .line_word, .line_accept,
        .rx_valid, .rx_word, .rx_ctrl, .rx_err, .no_signal, .init_match, .init_inverse,
        .rx_invert, .tx_drv_en, .tx_pll_en, .rx_en, .rx_cdr_en);
    lane_line_model lane_line_model_i (.ref_clk, .line_valid, .stall, .line_word, .line_accept,
        .got, .n);
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task hang;
        failures++;
        $display("mismatch at %0t: no answer", $time);
        results();
    endtask : hang
    task clk(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : clk
    // single word transfer: address phase, then data phase, each until hready
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        hsel <= 1; haddr <= a; htrans <= lane_pkg::htrans_nonseq; hwrite <= w;
        for (int p = 0; p < 2; p++) begin
            k = 0;
            do begin @(posedge ref_clk); if (++k > 20) hang(); end while (hreadyout !== 1'b1);
            if (p == 0) begin hsel <= 0; htrans <= '0; hwdata <= d; end
        end
        rd = hrdata;
    endtask : ahb
    // poll the state field until it matches or tries run out
    task st(input lane_pkg::lane_state_e s, input int tries);
        for (int i = 0; i < tries; i++) begin
            ahb(0, sa, '0);
            if (rd[3:0] === s) break;
        end
        chk(32'(rd[3:0]), 32'(s));
    endtask : st
    task send(input logic [31:0] w, input logic last);
        int k;
        k = 0;
        tx_req <= 1; tx_word <= w;
        do begin @(posedge ref_clk); if (++k > 50) hang(); end while (tx_ready !== 1'b1);
        if (last) tx_req <= 0;
    endtask : send
    task rxw(input logic [31:0] w, input logic c, input int cnt);
        rx_valid <= 1; rx_word <= w; rx_ctrl <= c;
        clk(cnt);
    endtask : rxw
    task t_reset;
        clk(3);
        chk(32'({hresp, tx_drv_en, tx_pll_en, rx_en, rx_cdr_en}), 32'h0);
        ahb(0, sa, '0);
        chk(32'(rd[4:0]), 32'h11);
        ahb(1, sa, 32'h10);
        clk(60);
        st(lane_pkg::line_quiet_state, 1);
        chk(32'(rd[4]), 32'h0);
        st(lane_pkg::disabled_state, 30);
    endtask : t_reset
    task t_start;
        ahb(1, ca, 32'h4);
        st(lane_pkg::started_state, 20);
        init_inverse <= 1; clk(1); init_inverse <= 0;
        ahb(0, lane_pkg::rxerr_addr, '0);
        chk(rd, 32'h8);
        rx_err <= 1; clk(1); rx_err <= 0;
        ahb(0, lane_pkg::rxerr_addr, '0);
        chk(rd, 32'h9);
        init_match <= 1;
        st(lane_pkg::connecting_state, 10);
        rxw(32'h0000_1234, 0, 256); rx_valid <= 0;
        ahb(0, lane_pkg::rxerr_addr, '0);
        chk(rd, 32'h1);
        rxw(32'h0000_1234, 0, 32); rx_valid <= 0;
        st(lane_pkg::active_state, 10);
        chk(32'({rd[7:5], status_ready}), 32'hf);
    endtask : t_start
    task t_tx;
        send(32'h0000_00a1, 1);
        clk(3);
        chk(32'({tx_ready, line_valid}), 32'h1);
        chk(line_word, 32'h0000_00a1);
        stall <= 0;
        send(32'h0000_00a2, 0);
        send(32'h0000_00a3, 1);
        clk(3);
        chk(got, 32'h0000_00a3);
        chk(32'(n), 32'h3);
    endtask : t_tx
    task t_rx;
        rxw(32'h5a5a_0001, 0, 1); rx_valid <= 0;
        clk(1);
        chk(32'(up_valid), 32'h1);
        chk(up_word, 32'h5a5a_0001);
    endtask : t_rx
    task t_consec;
        rxw(lane_pkg::standby_word, 1, 7); rxw(32'h1, 0, 1); rxw(lane_pkg::standby_word, 1, 7);
        rx_valid <= 0; clk(2);
        chk(32'(status_ready), 32'h1);
        rxw(lane_pkg::lost_signal_word, 1, 8); rx_valid <= 0; clk(2);
        chk(32'({status_ready, rx_invert, tx_drv_en, rx_en}), 32'h0);
        st(lane_pkg::line_quiet_state, 2);
    endtask : t_consec
    task t_cold;
        ahb(1, ca, 32'h5);
        clk(2);
        ahb(0, ca, '0);
        chk(32'(rd[2]), 32'h0);
        st(lane_pkg::line_quiet_state, 3);
        chk(32'(rd[4]), 32'h1);
        st(lane_pkg::disabled_state, 70);
        ahb(1, ca, 32'h2);
        st(lane_pkg::line_quiet_state, 3);
    endtask : t_cold
    // main sequence: reset, bring the lane up, traffic, then the reset paths
    initial begin
        clk(16); resetn <= 1;
        t_reset; t_start; t_tx; t_rx; t_consec; t_cold;
        results();
    end
endmodule : lane_layer_tb
bind lane_layer lane_layer_chk lane_layer_chk_i (.ref_clk, .resetn, .tx_req, .tx_ready,
    .line_valid, .line_accept, .rx_valid, .up_valid, .status_ind, .status_ready, .tx_drv_en,
    .tx_pll_en, .rx_en, .rx_cdr_en, .line_word);

// [lane_line_model.sv]
`timescale 1ns/1ns
// far end of the serial lane: takes each word unless told to stall
module lane_line_model (
    input wire logic        ref_clk, line_valid, stall,
    input wire logic [31:0] line_word,
    output logic            line_accept,
    output logic [31:0]     got,
    output int              n
);
    assign line_accept = line_valid && !stall;
    // record the last word taken and how many
    always @(posedge ref_clk) if (line_accept) begin
        got <= line_word;
        n <= n + 1;
    end
endmodule : lane_line_model

// [lane_pkg.sv]
package lane_pkg;
    // register map (byte addresses)
    localparam logic [7:0]  ctrl_addr          = 8'h00;
    localparam logic [7:0]  status_addr        = 8'h04;
    localparam logic [7:0]  rxerr_addr         = 8'h08;
    // control register fields
    localparam int          ctrl_full_reset    = 0;
    localparam int          ctrl_soft_reset    = 1;
    localparam int          ctrl_lane_start    = 2;
    localparam int          ctrl_self_go       = 3;
    localparam int          ctrl_sleep_req     = 4;
    localparam int          ctrl_loss_req      = 5;
    // status register fields
    localparam int          stat_state_lo      = 0;
    localparam int          stat_state_hi      = 3;
    localparam int          stat_hard_flag     = 4;
    localparam int          stat_locked        = 5;
    localparam int          stat_lane_ready    = 6;
    localparam int          stat_rx_invert     = 7;
    // line control word codes (arbitrary values)
    localparam logic [31:0] standby_word       = 32'h0000_00b1;
    localparam logic [31:0] lost_signal_word   = 32'h0000_00b2;
    // counts
    localparam logic [7:0]  rxerr_init         = 8'h08;
    localparam logic [7:0]  rxerr_max          = 8'hff;
    localparam logic [4:0]  rxerr_words_last   = 5'h1f;
    localparam logic [3:0]  consec_last        = 4'h7;
    localparam logic [5:0]  sleep_words_last   = 6'h1f;
    // timing
    localparam int          clk_mhz            = 50;
    localparam int          init_timeout_us    = 20;
    localparam int          quiet_time_us      = 2;
    localparam int          init_timeout_cyc   = init_timeout_us * clk_mhz;
    localparam int          quiet_time_cyc     = quiet_time_us * clk_mhz;
    // ahb
    localparam logic [1:0]  htrans_nonseq      = 2'h2;
    localparam logic [1:0]  htrans_seq         = 2'h3;

    typedef enum logic [3:0] {
        full_reset_state,
        line_quiet_state,
        disabled_state,
        wait_state,
        started_state,
        polarity_flip_state,
        connecting_state,
        connected_state,
        active_state,
        sleep_prepare_state,
        signal_gone_state
    } lane_state_e;
endpackage : lane_pkg

// [lane_timer.sv]
`timescale 1ns/1ns
// one-shot cycle counter: start loads, stop halts, done holds after expiry
module lane_timer #(
    parameter int unsigned CYCLES = 100
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic start,
    input  wire logic stop,
    output logic      expired
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        run;
    } tmr_s;

    tmr_s st_reg;
    tmr_s st_next;

    // load, count down, report expiry once count reaches zero
    always_comb begin
        st_next = st_reg;
        if (start) begin
            st_next.cnt = 16'(CYCLES - 1);
            st_next.run = 1'b1;
        end else if (stop) begin
            st_next.run = 1'b0;
        end else if (st_reg.run && st_reg.cnt != 16'h0000) begin
            st_next.cnt = st_reg.cnt - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.run && (st_reg.cnt == 16'h0000);
endmodule : lane_timer

// [rx_err_counter.sv]
`timescale 1ns/1ns
// clock-data recovery lock check: +1 per error, -1 per 32 words, locked at zero
module rx_err_counter (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       load,
    input  wire logic       rx_valid,
    input  wire logic       rx_err,
    output logic [7:0]      count,
    output logic            locked
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [4:0] words;
    } errc_s;

    errc_s st_reg;
    errc_s st_next;
    logic  dec;

    // error increments win over the word-count decrement in the same cycle
    always_comb begin
        st_next = st_reg;
        dec     = 1'b0;
        if (load) begin
            st_next.cnt   = lane_pkg::rxerr_init;
            st_next.words = '0;
        end else begin
            if (rx_valid) begin
                st_next.words = st_reg.words + 5'h01;
                dec = (st_reg.words == lane_pkg::rxerr_words_last);
            end
            if (rx_err && st_reg.cnt != lane_pkg::rxerr_max) begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end else if (dec && st_reg.cnt != 8'h00) begin
                st_next.cnt = st_reg.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{cnt: lane_pkg::rxerr_init, words: 5'h00};
        end else begin
            st_reg <= st_next;
        end
    end

    assign count  = st_reg.cnt;
    assign locked = (st_reg.cnt == 8'h00);
endmodule : rx_err_counter
